// file: design/pin_select_pkg.sv
// Constants, types and address map shared by the remappable pin select map
package pin_select_pkg;

   // Geometry of the selector bank
   localparam int FIELD_W     = 6;
   localparam int REG_W       = 16;
   localparam int NUM_IN_SEL  = 6;
   localparam int NUM_OUT_SEL = 4;
   localparam int NUM_FIELDS  = 10;
   localparam int NUM_REGS    = 6;
   localparam int PIN_COUNT   = 64;
   localparam int FUNC_COUNT  = 64;
   localparam int IDX_W       = 3;

   typedef logic [FIELD_W-1:0]                  sel_t;
   typedef logic [NUM_FIELDS-1:0][FIELD_W-1:0]  field_bank_t;

   // Byte offsets of the registers on the bus
   localparam logic [31:0] SPI2_SS_SEL_OFS    = 32'h0000_0000;
   localparam logic [31:0] UART4_SEL_OFS      = 32'h0000_0004;
   localparam logic [31:0] SPI3_CLK_DAT_OFS   = 32'h0000_0008;
   localparam logic [31:0] SPI3_SS_SEL_OFS    = 32'h0000_000C;
   localparam logic [31:0] PIN_OUT_0_1_OFS    = 32'h0000_0010;
   localparam logic [31:0] PIN_OUT_2_3_OFS    = 32'h0000_0014;

   // Word indices derived from the offsets
   localparam logic [IDX_W-1:0] PIN01_IDX    = PIN_OUT_0_1_OFS[4:2];
   localparam logic [IDX_W-1:0] LAST_IDX     = PIN_OUT_2_3_OFS[4:2];
   localparam logic [IDX_W-1:0] UNMAPPED_IDX = 3'h7;

   // Field positions inside a register word
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 8;

   // Field order: peripheral inputs first, then the four pin outputs
   localparam int F_SPI2_SS   = 0;
   localparam int F_UART4_RX  = 1;
   localparam int F_UART4_CTS = 2;
   localparam int F_SPI3_DAT  = 3;
   localparam int F_SPI3_CLK  = 4;
   localparam int F_SPI3_SS   = 5;
   localparam int F_PIN0      = 6;

   // Values after reset and the null output function
   localparam sel_t IN_SEL_RST  = 6'h3F;
   localparam sel_t OUT_SEL_RST = 6'h00;
   localparam sel_t FUNC_NONE   = 6'h00;
   localparam logic PERIPH_IDLE = 1'h1;

   // Register index and half (1 = bits 13-8) of every field
   localparam logic [NUM_FIELDS-1:0][IDX_W-1:0] FIELD_REG =
      {3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
   localparam logic [NUM_FIELDS-1:0] FIELD_HI = 10'h294;
   localparam field_bank_t FIELD_RST = {OUT_SEL_RST, OUT_SEL_RST, OUT_SEL_RST, OUT_SEL_RST,
      IN_SEL_RST, IN_SEL_RST, IN_SEL_RST, IN_SEL_RST, IN_SEL_RST, IN_SEL_RST};

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Routed peripheral inputs, bit 5 first
   typedef struct packed {
      logic spi3_slave_select_input;
      logic spi3_clock_input;
      logic spi3_data_input;
      logic uart4_clear_to_send_input;
      logic uart4_receive_input;
      logic spi2_slave_select_input;
   } periph_in_s;

   // True for any address inside the six-register map; bits 1-0 are not checked
   function automatic logic addr_hit(input logic [31:0] addr);
      return (addr[31:5] == 27'h0000000) && (addr[4:2] <= LAST_IDX);
   endfunction : addr_hit

endpackage : pin_select_pkg

// file: design/sel_field_bank.sv
// Selector field storage with a registered read port
module sel_field_bank (
   input  wire logic                                     clk_in,
   input  wire logic                                     rst_n_in,
   input  wire logic                                     wr_en_in,
   input  wire logic [pin_select_pkg::IDX_W-1:0]         wr_idx_in,
   input  wire logic [pin_select_pkg::REG_W-1:0]         wr_data_in,
   input  wire logic [1:0]                               wr_strb_in,
   input  wire logic                                     rd_en_in,
   input  wire logic [pin_select_pkg::IDX_W-1:0]         rd_idx_in,
   output logic      [pin_select_pkg::REG_W-1:0]         rd_data_out,
   output pin_select_pkg::field_bank_t                   fields_out
);

   pin_select_pkg::field_bank_t           field_q;
   logic [pin_select_pkg::REG_W-1:0]      rd_data_q;
   logic [pin_select_pkg::REG_W-1:0]      rd_word_d;

   // One six-bit field per entry; a write lands only on its own byte lane
   for (genvar f = 0; f < pin_select_pkg::NUM_FIELDS; f++) begin : g_field
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            field_q[f] <= pin_select_pkg::FIELD_RST[f];
         end else if (wr_en_in && wr_idx_in == pin_select_pkg::FIELD_REG[f]
                      && wr_strb_in[pin_select_pkg::FIELD_HI[f]]) begin
            field_q[f] <= pin_select_pkg::FIELD_HI[f]
               ? wr_data_in[pin_select_pkg::HI_LSB +: pin_select_pkg::FIELD_W]
               : wr_data_in[pin_select_pkg::LO_LSB +: pin_select_pkg::FIELD_W];
         end
      end
   end

   // Assemble a word; bits that hold no field stay zero
   always_comb begin
      rd_word_d = 16'h0000;
      for (int f = 0; f < pin_select_pkg::NUM_FIELDS; f++) begin
         if (rd_idx_in == pin_select_pkg::FIELD_REG[f]) begin
            if (pin_select_pkg::FIELD_HI[f]) begin
               rd_word_d[pin_select_pkg::HI_LSB +: pin_select_pkg::FIELD_W] = field_q[f];
            end else begin
               rd_word_d[pin_select_pkg::LO_LSB +: pin_select_pkg::FIELD_W] = field_q[f];
            end
         end
      end
   end

   // Read data held in a register until the next read
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_q <= 16'h0000;
      end else if (rd_en_in) begin
         rd_data_q <= rd_word_d;
      end
   end

   assign rd_data_out = rd_data_q;
   assign fields_out  = field_q;

endmodule : sel_field_bank

// file: design/pin_select_map.sv
// Remappable pin select map: register slave, input routing and pin output routing
////////////////////////////////////////////////////////////////////////////////
// Function
// - Bits 5-0 of own register pick the pin feeding SPI2 slave select.
// - Bits 13-8 of shared register pick the pin feeding UART4 clear-to-send.
// - Bits 5-0 of that register pick the pin feeding UART4 receive.
// - Bits 13-8 of shared register pick the pin feeding SPI3 clock.
// - Bits 5-0 of that register pick the pin feeding SPI3 data.
// - Bits 5-0 of own register pick SPI3 slave select pin; upper bits unused.
// - Pin 0 field, bits 5-0, routes output function n onto the pin.
// - Pin 1 field, bits 13-8 of first output register, routes function n.
// - Second output register: pin 2 in bits 5-0, pin 3 in 13-8.
// - Unimplemented bits read zero and ignore writes.
// - Reset sets every peripheral input selector bit to one.
// - Reset clears every pin output selector field to zero.
////////////////////////////////////////////////////////////////////////////////
module pin_select_map (
   input  wire logic                                         CORE_CLK_IN,
   input  wire logic                                         ARST_N_IN,
   input  wire logic                                         S_AXI_AWVALID_IN,
   output logic                                              S_AXI_AWREADY_OUT,
   input  wire logic [31:0]                                  S_AXI_AWADDR_IN,
   input  wire logic [2:0]                                   S_AXI_AWPROT_IN,
   input  wire logic                                         S_AXI_WVALID_IN,
   output logic                                              S_AXI_WREADY_OUT,
   input  wire logic [31:0]                                  S_AXI_WDATA_IN,
   input  wire logic [3:0]                                   S_AXI_WSTRB_IN,
   output logic                                              S_AXI_BVALID_OUT,
   input  wire logic                                         S_AXI_BREADY_IN,
   output logic      [1:0]                                   S_AXI_BRESP_OUT,
   input  wire logic                                         S_AXI_ARVALID_IN,
   output logic                                              S_AXI_ARREADY_OUT,
   input  wire logic [31:0]                                  S_AXI_ARADDR_IN,
   input  wire logic [2:0]                                   S_AXI_ARPROT_IN,
   output logic                                              S_AXI_RVALID_OUT,
   input  wire logic                                         S_AXI_RREADY_IN,
   output logic      [31:0]                                  S_AXI_RDATA_OUT,
   output logic      [1:0]                                   S_AXI_RRESP_OUT,
   input  wire logic [pin_select_pkg::PIN_COUNT-1:0]         PIN_IN,
   input  wire logic [pin_select_pkg::FUNC_COUNT-1:0]        FUNC_IN,
   output pin_select_pkg::periph_in_s                        PERIPH_IN_OUT,
   output logic      [pin_select_pkg::NUM_OUT_SEL-1:0]       PIN_DATA_OUT,
   output logic      [pin_select_pkg::NUM_OUT_SEL-1:0]       PIN_OE_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Reset release

   logic rst_meta_q;
   logic rst_n_q;

   // Assert at once, release two edges later so no flop sees a ragged edge
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_meta_q <= 1'h0;
         rst_n_q    <= 1'h0;
      end else begin
         rst_meta_q <= 1'h1;
         rst_n_q    <= rst_meta_q;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Write channel

   logic        awready_q;
   logic        wready_q;
   logic        aw_have_q;
   logic        w_have_q;
   logic [31:0] awaddr_q;
   logic [15:0] wdata_q;
   logic [1:0]  wstrb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        aw_fire;
   logic        w_fire;
   logic        wr_go;
   logic        wr_hit;

   assign aw_fire = S_AXI_AWVALID_IN & awready_q;
   assign w_fire  = S_AXI_WVALID_IN & wready_q;
   // Address and data may arrive in either order; commit once both are held
   assign wr_go   = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_hit  = pin_select_pkg::addr_hit(awaddr_q);

   // Address capture; ready stays low until the response is taken
   always_ff @(posedge CORE_CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         awready_q <= 1'h1;
         aw_have_q <= 1'h0;
         awaddr_q  <= 32'h0000_0000;
      end else if (aw_fire) begin
         awready_q <= 1'h0;
         aw_have_q <= 1'h1;
         awaddr_q  <= S_AXI_AWADDR_IN;
      end else if (wr_go) begin
         aw_have_q <= 1'h0;
      end else if (bvalid_q && S_AXI_BREADY_IN) begin
         awready_q <= 1'h1;
      end
   end

   // Data capture; only the low two lanes carry implemented bits
   always_ff @(posedge CORE_CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wready_q <= 1'h1;
         w_have_q <= 1'h0;
         wdata_q  <= 16'h0000;
         wstrb_q  <= 2'h0;
      end else if (w_fire) begin
         wready_q <= 1'h0;
         w_have_q <= 1'h1;
         wdata_q  <= S_AXI_WDATA_IN[15:0];
         wstrb_q  <= S_AXI_WSTRB_IN[1:0];
      end else if (wr_go) begin
         w_have_q <= 1'h0;
      end else if (bvalid_q && S_AXI_BREADY_IN) begin
         wready_q <= 1'h1;
      end
   end

   // Write response; an address outside the map is refused and stores nothing
   always_ff @(posedge CORE_CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bvalid_q <= 1'h0;
         bresp_q  <= pin_select_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'h1;
         bresp_q  <= wr_hit ? pin_select_pkg::RESP_OKAY : pin_select_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY_IN) begin
         bvalid_q <= 1'h0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Read channel

   typedef enum logic {RD_IDLE, RD_RESP} rd_state_e;

   rd_state_e                          rd_state_q;
   logic                               arready_q;
   logic                               rvalid_q;
   logic [1:0]                         rresp_q;
   logic                               ar_fire;
   logic                               ar_hit;
   logic [pin_select_pkg::IDX_W-1:0]   rd_idx;

   assign ar_fire = S_AXI_ARVALID_IN & arready_q;
   assign ar_hit  = pin_select_pkg::addr_hit(S_AXI_ARADDR_IN);
   // An unmapped read points the bank at an empty index, so data read zero
   assign rd_idx  = ar_hit ? S_AXI_ARADDR_IN[4:2] : pin_select_pkg::UNMAPPED_IDX;

   // Data is loaded into the bank register on the same edge that takes the address
   always_ff @(posedge CORE_CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_state_q <= RD_IDLE;
         arready_q  <= 1'h1;
         rvalid_q   <= 1'h0;
         rresp_q    <= pin_select_pkg::RESP_OKAY;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               if (ar_fire) begin
                  rd_state_q <= RD_RESP;
                  arready_q  <= 1'h0;
                  rvalid_q   <= 1'h1;
                  rresp_q    <= ar_hit ? pin_select_pkg::RESP_OKAY
                                       : pin_select_pkg::RESP_SLVERR;
               end
            end
            RD_RESP: begin
               if (S_AXI_RREADY_IN) begin
                  rd_state_q <= RD_IDLE;
                  arready_q  <= 1'h1;
                  rvalid_q   <= 1'h0;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
               arready_q  <= 1'h1;
               rvalid_q   <= 1'h0;
            end
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Selector storage

   pin_select_pkg::field_bank_t   fields_w;
   logic [15:0]                   rd_data_w;

   // Unimplemented bits have no storage at all, so writes to them vanish
   sel_field_bank u_bank (
      .clk_in      (CORE_CLK_IN),
      .rst_n_in    (rst_n_q),
      .wr_en_in    (wr_go & wr_hit),
      .wr_idx_in   (awaddr_q[4:2]),
      .wr_data_in  (wdata_q),
      .wr_strb_in  (wstrb_q),
      .rd_en_in    (ar_fire),
      .rd_idx_in   (rd_idx),
      .rd_data_out (rd_data_w),
      .fields_out  (fields_w)
   );

////////////////////////////////////////////////////////////////////////////////
// Routing

   logic [pin_select_pkg::NUM_IN_SEL-1:0]   periph_q;
   logic [pin_select_pkg::NUM_IN_SEL-1:0]   pick_w;
   logic [pin_select_pkg::NUM_OUT_SEL-1:0]  pin_data_q;
   logic [pin_select_pkg::NUM_OUT_SEL-1:0]  pin_oe_q;
   logic [pin_select_pkg::NUM_OUT_SEL-1:0]  out_pick_w;
   logic [pin_select_pkg::NUM_OUT_SEL-1:0]  out_en_w;

   // Each peripheral input samples the pin its selector names; registering
   // costs a cycle but keeps the wide mux off the peripheral's timing path
   for (genvar i = 0; i < pin_select_pkg::NUM_IN_SEL; i++) begin : g_in_route
      assign pick_w[i] = PIN_IN[fields_w[i]];
      always_ff @(posedge CORE_CLK_IN or negedge rst_n_q) begin
         if (!rst_n_q) begin
            periph_q[i] <= pin_select_pkg::PERIPH_IDLE;
         end else begin
            periph_q[i] <= pick_w[i];
         end
      end
   end

   // Function zero is the null output: the pin is released, not driven low
   for (genvar j = 0; j < pin_select_pkg::NUM_OUT_SEL; j++) begin : g_out_route
      assign out_en_w[j]   = fields_w[pin_select_pkg::NUM_IN_SEL + j] != pin_select_pkg::FUNC_NONE;
      assign out_pick_w[j] = out_en_w[j] & FUNC_IN[fields_w[pin_select_pkg::NUM_IN_SEL + j]];
      always_ff @(posedge CORE_CLK_IN or negedge rst_n_q) begin
         if (!rst_n_q) begin
            pin_data_q[j] <= 1'h0;
            pin_oe_q[j]   <= 1'h0;
         end else begin
            pin_data_q[j] <= out_pick_w[j];
            pin_oe_q[j]   <= out_en_w[j];
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Outputs

   assign S_AXI_AWREADY_OUT = awready_q;
   assign S_AXI_WREADY_OUT  = wready_q;
   assign S_AXI_BVALID_OUT  = bvalid_q;
   assign S_AXI_BRESP_OUT   = bresp_q;
   assign S_AXI_ARREADY_OUT = arready_q;
   assign S_AXI_RVALID_OUT  = rvalid_q;
   assign S_AXI_RRESP_OUT   = rresp_q;
   // Upper half of the word always reads zero
   assign S_AXI_RDATA_OUT   = {16'h0000, rd_data_w};
   assign PERIPH_IN_OUT     = pin_select_pkg::periph_in_s'(periph_q);
   assign PIN_DATA_OUT      = pin_data_q;
   assign PIN_OE_OUT        = pin_oe_q;

////////////////////////////////////////////////////////////////////////////////
// Checks

   default clocking cb_core @(posedge CORE_CLK_IN); endclocking
   default disable iff (!rst_n_q);

   logic [5:0] wlo_w;
   assign wlo_w = wdata_q[5:0];

   // A low-lane write to the pin 0/1 register
   sequence pin0_write_s;
      wr_go && wr_hit && awaddr_q[4:2] == pin_select_pkg::PIN01_IDX && wstrb_q[0];
   endsequence

   // The field then holds the written value
   sequence pin0_held_s;
      fields_w[pin_select_pkg::F_PIN0] == $past(wlo_w);
   endsequence

   chk_spi2_ss_route: assert property (
      $past(rst_n_q) |-> periph_q[pin_select_pkg::F_SPI2_SS]
                         == $past(pick_w[pin_select_pkg::F_SPI2_SS]))
      else $error("SPI2 slave select does not follow its pin");

   chk_uart4_route: assert property (
      $past(rst_n_q) |-> periph_q[2:1] == $past(pick_w[2:1]))
      else $error("UART4 inputs do not follow their pins");

   chk_spi3_clk_data: assert property (
      $past(rst_n_q) |-> periph_q[4:3] == $past(pick_w[4:3]))
      else $error("SPI3 clock or data does not follow its pin");

   chk_spi3_ss_route: assert property (
      $past(rst_n_q) |-> periph_q[pin_select_pkg::F_SPI3_SS]
                         == $past(pick_w[pin_select_pkg::F_SPI3_SS]))
      else $error("SPI3 slave select does not follow its pin");

   chk_pin0_drive: assert property (
      $past(rst_n_q) |-> pin_data_q[0] == $past(out_pick_w[0])
                         && pin_oe_q[0] == $past(out_en_w[0]))
      else $error("Pin 0 not driven by its selected function");

   chk_pin1_drive: assert property (
      $past(rst_n_q) |-> pin_oe_q[1] == ($past(fields_w[7]) != pin_select_pkg::FUNC_NONE)
                         && pin_data_q[1] == ($past(FUNC_IN[fields_w[7]]) && pin_oe_q[1]))
      else $error("Pin 1 not driven by its selected function");

   chk_pin2_3_drive: assert property (
      $past(rst_n_q) |-> pin_data_q[3:2] == $past(out_pick_w[3:2])
                         && pin_oe_q[3:2] == $past(out_en_w[3:2]))
      else $error("Pin 2 or 3 not driven by its selected function");

   chk_unused_zero: assert property (
      rvalid_q |-> S_AXI_RDATA_OUT[31:14] == 18'h00000 && S_AXI_RDATA_OUT[7:6] == 2'h0)
      else $error("Unimplemented read data bits not zero");

   chk_in_sel_reset: assert property (
      $rose(rst_n_q) |-> fields_w[5:0] == pin_select_pkg::FIELD_RST[5:0]
                         && fields_w[0] == pin_select_pkg::IN_SEL_RST)
      else $error("Input selectors not all ones after reset");

   chk_out_sel_reset: assert property (
      $rose(rst_n_q) |-> fields_w[9:6] == 24'h000000 && pin_oe_q == 4'h0)
      else $error("Output selectors not zero after reset");

   chk_write_takes: assert property (
      pin0_write_s |=> pin0_held_s ##1 pin_oe_q[0] == $past(out_en_w[0]))
      else $error("Pin 0 selector write not stored or not applied");

   chk_read_answer: assert property (
      ar_fire |=> rvalid_q && !arready_q && S_AXI_RDATA_OUT[15:0] == rd_data_w
                  && S_AXI_RRESP_OUT == ($past(ar_hit) ? pin_select_pkg::RESP_OKAY
                                                       : pin_select_pkg::RESP_SLVERR))
      else $error("Read address taken without the right answer next cycle");

   // Single-field registers have nothing above bit 5 to show
   chk_single_upper: assert property (
      ar_fire && ar_hit
      && (rd_idx == pin_select_pkg::FIELD_REG[pin_select_pkg::F_SPI2_SS]
          || rd_idx == pin_select_pkg::FIELD_REG[pin_select_pkg::F_SPI3_SS])
      |=> S_AXI_RDATA_OUT[15:6] == 10'h000)
      else $error("Single-field register shows bits above its field");

   chk_write_answer: assert property (
      wr_go |=> bvalid_q && (bresp_q == pin_select_pkg::RESP_OKAY) == $past(wr_hit))
      else $error("Write not answered with the right response");

endmodule : pin_select_map

// file: verif/pin_func_model.sv
// Remappable pins and peripheral output functions seen from outside the selector block
module pin_func_model (
   input  wire logic        clk_in,
   input  wire logic        flip_in,
   output logic      [63:0] pin_out,
   output logic      [63:0] func_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin 63 stays high so the reset selection reads as an idle, unassigned pin
   always_ff @(posedge clk_in) begin
      pin_out  <= flip_in ? 64'hDA3C_F069_A5C3_0F96 : 64'hA5C3_0F96_5A3C_F069;
      func_out <= flip_in ? 64'h94D2_6E1B_3780_C5A1 : 64'h6B2D_91E4_C87F_3A5E;
   end
endmodule : pin_func_model

// file: verif/tb_top.sv
// Self-checking bench for the remappable pin select map
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic arv = 1'b0, rry = 1'b0, flip = 1'b0, awr, wrd, bv, arr, rv;
   logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
   logic [3:0]  ws = 4'h0, pdat, poe;
   logic [1:0]  br, rr, resp;
   logic [63:0] pin, fn;
   logic [31:0] got;
   pin_select_pkg::periph_in_s pi;
   int fail_count = 0, check_count = 0;
   // Table rows: address, data, strobes, expected read-back, expected answer
   logic [31:0] ra [8] = '{32'h00, 32'h04, 32'h04, 32'h08, 32'h0C, 32'h10, 32'h14, 32'h18};
   logic [31:0] rw [8] = '{32'hFFFF_FFEA, 32'hFFFF_5525, 32'h7, 32'h3F01, 32'hFFFF_FFFF,
                           32'h0305, 32'h2A07, 32'h1};
   logic [3:0]  rs [8] = '{4'hF, 4'hF, 4'h1, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
   logic [31:0] re [8] = '{32'h2A, 32'h1525, 32'h1507, 32'h3F01, 32'h3F, 32'h0305,
                           32'h2A07, 32'h0};
   logic [1:0]  rp [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
   logic [31:0] rst_val [6] = '{32'h3F, 32'h3F3F, 32'h3F3F, 32'h3F, 32'h0, 32'h0};

   always #20 clk = ~clk;

   pin_func_model partner (.clk_in(clk), .flip_in(flip), .pin_out(pin), .func_out(fn));

   pin_select_map dut (
      .CORE_CLK_IN(clk), .ARST_N_IN(rst_n),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa),
      .S_AXI_AWPROT_IN(3'h0), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
      .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_BVALID_OUT(bv),
      .S_AXI_BREADY_IN(bry), .S_AXI_BRESP_OUT(br), .S_AXI_ARVALID_IN(arv),
      .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara), .S_AXI_ARPROT_IN(3'h0),
      .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry), .S_AXI_RDATA_OUT(rd),
      .S_AXI_RRESP_OUT(rr), .PIN_IN(pin), .FUNC_IN(fn), .PERIPH_IN_OUT(pi),
      .PIN_DATA_OUT(pdat), .PIN_OE_OUT(poe));

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   // Write: address and data offered together, each released once taken
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= s; bry <= 1'b1;
      // Only the watchdog ends a wait that never sees the answer
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (!bv);
      resp = br;
      bry <= 1'b0;
      @(posedge clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a);
      arv <= 1'b1; ara <= a; rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      got = rd; resp = rr;
      rry <= 1'b0;
      @(posedge clk);
   endtask : axi_rd

   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // Cuts a hang short well past the hundred or so cycles the tests need
   initial begin
      #400000;
      fail_count++;
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Table loop: write, answer code, read-back
      for (int i = 0; i < 8; i++) begin
         axi_wr(ra[i], rw[i], rs[i]);
         cmp("bresp", {30'h0, rp[i]}, {30'h0, resp});
         axi_rd(ra[i]);
         cmp("rdata", re[i], got);
         cmp("rresp", {30'h0, rp[i]}, {30'h0, resp});
      end
      // Routing from both partner patterns; new selections need a couple of edges
      for (int k = 0; k < 2; k++) begin
         flip <= k[0];
         repeat (3) @(posedge clk);
         cmp("periph", {26'h0, pin[63], pin[63], pin[1], pin[21], pin[7], pin[42]}, {26'h0, pi});
         cmp("pdat", {28'h0, fn[42], fn[7], fn[3], fn[5]}, {28'h0, pdat});
         cmp("poe", 32'hF, {28'h0, poe});
      end
      // Null function on pins 0 and 1 releases them
      axi_wr(32'h10, 32'h0, 4'hF);
      repeat (3) @(posedge clk);
      cmp("poe_off", 32'hC, {28'h0, poe});
      cmp("pdat_off", {28'h0, fn[42], fn[7], 2'h0}, {28'h0, pdat});
      // Second reset in mid-run restores every selector
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      cmp("rst_periph", 32'h3F, {26'h0, pi});
      cmp("rst_poe", 32'h0, {28'h0, poe});
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         axi_rd(ra[i == 0 ? 0 : i + 1]);
         cmp("rst_val", rst_val[i], got);
      end
      give_verdict();
   end
endmodule : tb_top
